// ===== pkg/label_gap_defs.vh
// constants for the label/gap sensor setup controller
`ifndef LABEL_GAP_DEFS_VH
`define LABEL_GAP_DEFS_VH

// ************************************
// timing, clock at 125 MHz
// ************************************
`define CYC_PER_MS        32'd125000
`define T_DEB_MS          32'd10
`define T_2S_MS           32'd2000
`define T_10S_MS          32'd10000
`define T_15S_MS          32'd15000
`define T_20S_MS          32'd20000
`define T_IDLE_MS         32'd10000
`define T_SLOW_HALF_MS    32'd250
`define T_FAST_HALF_MS    32'd60

// ************************************
// register byte offsets
// ************************************
`define REG_CTRL          8'h00
`define REG_CFG           8'h04
`define REG_STATUS        8'h08
`define REG_INT_STAT      8'h0c
`define REG_INT_MASK      8'h10

// ************************************
// field positions
// ************************************
`define CTRL_LOCK_BIT     0
`define CFG_TYPE_BIT      0
`define CFG_OFFS_LSB      8
`define CFG_OFFS_MSB      12
`define ST_SW_BIT         0
`define ST_BTN_BIT        1
`define ST_TEACH_OK_BIT   2
`define ST_STATE_LSB      8
`define ST_STATE_MSB      14
`define INT_END_BIT       0
`define INT_TOK_BIT       1
`define INT_TFAIL_BIT     2
`define INT_CFG_BIT       3
`define INT_W             4

// ************************************
// values
// ************************************
`define OFFS_MIN          5'h01
`define OFFS_MAX          5'h14
`define OFFS_PAPER        5'h06
`define OFFS_METAL        5'h0a
`define TYPE_PAPER        1'b0
`define TYPE_METAL        1'b1
`define BLINK_OK          5'h02
`define BLINK_FAIL        5'h04
`define BAND_NONE         3'h0
`define BAND_TEACH        3'h1
`define BAND_MAT          3'h2
`define BAND_OFFS         3'h3
`define BAND_FACT         3'h4

`endif

// ===== rtl/btn_debounce.v
// synchroniser and debouncer for the set button
module btn_debounce #(
   parameter [31:0] T_DEB = 32'd1250000
) (
   input  wire       hclk,
   input  wire       hresetn,
   input  wire       btn_pin,
   output reg        btn_level,
   output reg        btn_rise,
   output reg        btn_fall
);

   reg        sync1_r;
   reg        sync2_r;
   reg [31:0] stab_r;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_r   <= 1'b0;
         sync2_r   <= 1'b0;
         stab_r    <= 32'h00000000;
         btn_level <= 1'b0;
         btn_rise  <= 1'b0;
         btn_fall  <= 1'b0;
      end else begin
         sync1_r  <= btn_pin;
         sync2_r  <= sync1_r;
         btn_rise <= 1'b0;
         btn_fall <= 1'b0;
         // level accepted only after it stood still for the debounce time
         if (sync2_r == btn_level) begin
            stab_r <= 32'h00000000;
         end else if (stab_r >= T_DEB - 32'd1) begin
            stab_r    <= 32'h00000000;
            btn_level <= sync2_r;
            btn_rise  <= sync2_r;
            btn_fall  <= ~sync2_r;
         end else begin
            stab_r <= stab_r + 32'd1;
         end
      end
   end

endmodule // btn_debounce

// ===== rtl/label_gap_sensor_setup_fsm.v
// label/gap sensor controller: output, led, set-button menu and ahb-lite registers
//
// Decided for this implementation: the register addresses and register access over AHB-Lite.
`include "label_gap_defs.vh"

module label_gap_sensor_setup_fsm #(
   parameter [31:0] T_DEB       = `T_DEB_MS * `CYC_PER_MS,
   parameter [31:0] T_2S        = `T_2S_MS * `CYC_PER_MS,
   parameter [31:0] T_10S       = `T_10S_MS * `CYC_PER_MS,
   parameter [31:0] T_15S       = `T_15S_MS * `CYC_PER_MS,
   parameter [31:0] T_20S       = `T_20S_MS * `CYC_PER_MS,
   parameter [31:0] T_IDLE      = `T_IDLE_MS * `CYC_PER_MS,
   parameter [31:0] T_SLOW_HALF = `T_SLOW_HALF_MS * `CYC_PER_MS,
   parameter [31:0] T_FAST_HALF = `T_FAST_HALF_MS * `CYC_PER_MS
) (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output reg  [31:0] hrdata,
   input  wire        btn_pin,
   input  wire        label_pin,
   input  wire        teach_done,
   input  wire        teach_ok,
   output reg         sw_out,
   output reg         led_green,
   output reg         led_red,
   output reg         teach_start,
   output reg         label_type,
   output reg  [4:0]  offset,
   output wire        irq
);

   // ************************************
   // states
   // ************************************
   localparam [6:0] S_WORK  = 7'h01;
   localparam [6:0] S_HOLD  = 7'h02;
   localparam [6:0] S_TEACH = 7'h04;
   localparam [6:0] S_LTYPE = 7'h08;
   localparam [6:0] S_OFFS  = 7'h10;
   localparam [6:0] S_SHOW  = 7'h20;
   localparam [6:0] S_OHOLD = 7'h40;

   // ************************************
   // functions
   // ************************************
   function [2:0] band;
      input [31:0] t;
      begin
         if (t <= T_2S)
            band = `BAND_NONE;
         else if (t <= T_10S)
            band = `BAND_TEACH;
         else if (t <= T_15S)
            band = `BAND_MAT;
         else if (t <= T_20S)
            band = `BAND_OFFS;
         else
            band = `BAND_FACT;
      end
   endfunction

   function [4:0] clamp_offs;
      input [5:0] v;
      begin
         if (v < {1'b0, `OFFS_MIN})
            clamp_offs = `OFFS_MIN;
         else if (v > {1'b0, `OFFS_MAX})
            clamp_offs = `OFFS_MAX;
         else
            clamp_offs = v[4:0];
      end
   endfunction

   // ************************************
   // declarations
   // ************************************
   wire              btn_level;
   wire              btn_rise;
   wire              btn_fall;
   reg               lab1_r;
   reg               lab2_r;
   reg  [6:0]        state_r;
   reg  [31:0]       hold_r;
   reg  [31:0]       idle_r;
   reg  [4:0]        blink_left_r;
   reg  [31:0]       blink_ph_r;
   reg               blink_on_r;
   reg  [31:0]       fast_ph_r;
   reg               fast_on_r;
   reg               lock_r;
   reg               tok_r;
   reg               show_red_r;
   reg  [`INT_W-1:0] int_stat_r;
   reg  [`INT_W-1:0] int_mask_r;
   reg               wr_pend_r;
   reg               rd_pend_r;
   reg  [7:0]        addr_r;
   reg               func_end;
   reg               blink_load;
   reg  [4:0]        blink_n;
   reg  [`INT_W-1:0] ev;
   wire              acc;
   wire              idle_out;
   wire [2:0]        hold_band;

   assign hold_band = band(hold_r);
   assign idle_out  = (idle_r >= T_IDLE);
   assign acc       = hsel && htrans[1] && hready;
   assign hreadyout = ~rd_pend_r;
   assign hresp     = 1'b0;
   assign irq       = |(int_stat_r & int_mask_r);

   btn_debounce #(
      .T_DEB     (T_DEB)
   ) u_deb (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .btn_pin   (btn_pin),
      .btn_level (btn_level),
      .btn_rise  (btn_rise),
      .btn_fall  (btn_fall)
   );

   // ************************************
   // switching output
   // ************************************
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lab1_r <= 1'b0;
         lab2_r <= 1'b0;
         sw_out <= 1'b0;
      end else begin
         lab1_r <= label_pin;
         lab2_r <= lab1_r;
         sw_out <= lab2_r;
      end
   end

   // ************************************
   // hold and idle timers
   // ************************************
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hold_r <= 32'h00000000;
         idle_r <= 32'h00000000;
      end else begin
         if (func_end || btn_rise)
            hold_r <= 32'h00000000;
         else if (btn_level && hold_r != 32'hffffffff)
            hold_r <= hold_r + 32'd1;
         if (btn_level || btn_fall || state_r == S_HOLD)
            idle_r <= 32'h00000000;
         else if (!idle_out)
            idle_r <= idle_r + 32'd1;
      end
   end

   // ************************************
   // blink engines
   // ************************************
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         blink_left_r <= 5'h00;
         blink_ph_r   <= 32'h00000000;
         blink_on_r   <= 1'b0;
         fast_ph_r    <= 32'h00000000;
         fast_on_r    <= 1'b0;
      end else begin
         if (fast_ph_r >= T_FAST_HALF - 32'd1) begin
            fast_ph_r <= 32'h00000000;
            fast_on_r <= ~fast_on_r;
         end else begin
            fast_ph_r <= fast_ph_r + 32'd1;
         end
         // counted slow blinks: on half, off half, per blink
         if (blink_load) begin
            blink_left_r <= blink_n;
            blink_ph_r   <= 32'h00000000;
            blink_on_r   <= (blink_n != 5'h00);
         end else if (blink_left_r != 5'h00) begin
            if (blink_ph_r >= T_SLOW_HALF - 32'd1) begin
               blink_ph_r <= 32'h00000000;
               if (blink_on_r) begin
                  blink_on_r <= 1'b0;
               end else begin
                  blink_left_r <= blink_left_r - 5'h01;
                  blink_on_r   <= (blink_left_r != 5'h01);
               end
            end else begin
               blink_ph_r <= blink_ph_r + 32'd1;
            end
         end
      end
   end

   // ************************************
   // menu state machine
   // ************************************
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r     <= S_WORK;
         label_type  <= `TYPE_PAPER;
         offset      <= `OFFS_PAPER;
         teach_start <= 1'b0;
         tok_r       <= 1'b0;
         show_red_r  <= 1'b0;
         func_end    <= 1'b0;
         blink_load  <= 1'b0;
         blink_n     <= 5'h00;
         ev          <= {`INT_W{1'b0}};
      end else begin
         teach_start <= 1'b0;
         func_end    <= 1'b0;
         blink_load  <= 1'b0;
         ev          <= {`INT_W{1'b0}};
         case (state_r)
            S_WORK: begin
               if (btn_rise && !lock_r)
                  state_r <= S_HOLD;
            end
            S_HOLD: begin
               if (btn_fall) begin
                  case (hold_band)
                     `BAND_TEACH: begin
                        teach_start <= 1'b1;
                        state_r     <= S_TEACH;
                     end
                     `BAND_MAT: begin
                        state_r <= S_LTYPE;
                     end
                     `BAND_OFFS: begin
                        blink_n    <= offset;
                        blink_load <= 1'b1;
                        state_r    <= S_OFFS;
                     end
                     `BAND_FACT: begin
                        label_type <= `TYPE_PAPER;
                        show_red_r <= 1'b0;
                        offset     <= `OFFS_PAPER;
                        ev[`INT_CFG_BIT] <= 1'b1;
                        blink_n    <= `BLINK_OK;
                        blink_load <= 1'b1;
                        state_r    <= S_SHOW;
                     end
                     default: begin
                        state_r  <= S_WORK;
                        func_end <= 1'b1;
                     end
                  endcase
               end
            end
            S_TEACH: begin
               if (teach_done) begin
                  tok_r      <= teach_ok;
                  show_red_r <= ~teach_ok;
                  blink_n    <= teach_ok ? `BLINK_OK : `BLINK_FAIL;
                  blink_load <= 1'b1;
                  ev[`INT_TOK_BIT]   <= teach_ok;
                  ev[`INT_TFAIL_BIT] <= ~teach_ok;
                  state_r    <= S_SHOW;
               end
            end
            S_LTYPE: begin
               if (btn_rise) begin
                  label_type <= ~label_type;
                  ev[`INT_CFG_BIT] <= 1'b1;
               end else if (idle_out) begin
                  state_r  <= S_WORK;
                  func_end <= 1'b1;
                  ev[`INT_END_BIT] <= 1'b1;
               end
            end
            S_OFFS: begin
               if (btn_rise) begin
                  state_r <= S_OHOLD;
               end else if (idle_out) begin
                  state_r  <= S_WORK;
                  func_end <= 1'b1;
                  ev[`INT_END_BIT] <= 1'b1;
               end
            end
            S_OHOLD: begin
               if (btn_fall) begin
                  if (hold_r > T_2S) begin
                     offset  <= clamp_offs({1'b0, offset} - 6'h01);
                     blink_n <= clamp_offs({1'b0, offset} - 6'h01);
                  end else begin
                     offset  <= clamp_offs({1'b0, offset} + 6'h01);
                     blink_n <= clamp_offs({1'b0, offset} + 6'h01);
                  end
                  blink_load <= 1'b1;
                  ev[`INT_CFG_BIT] <= 1'b1;
                  state_r <= S_OFFS;
               end
            end
            S_SHOW: begin
               if (!blink_load && blink_left_r == 5'h00) begin
                  state_r  <= S_WORK;
                  func_end <= 1'b1;
                  ev[`INT_END_BIT] <= 1'b1;
               end
            end
            default: begin
               state_r <= S_WORK;
            end
         endcase
         // software may rewrite the configuration only while the menu is idle
         if (wr_pend_r && addr_r == `REG_CFG && state_r == S_WORK) begin
            label_type <= hwdata[`CFG_TYPE_BIT];
            offset     <= clamp_offs({1'b0, hwdata[`CFG_OFFS_MSB:`CFG_OFFS_LSB]});
         end
      end
   end

   // ************************************
   // led drive
   // ************************************
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         led_green <= 1'b0;
         led_red   <= 1'b0;
      end else begin
         led_red <= 1'b0;
         case (state_r)
            S_WORK:  led_green <= lab2_r;
            S_HOLD: begin
               case (hold_band)
                  `BAND_TEACH: led_green <= 1'b1;
                  `BAND_MAT:   led_green <= fast_on_r;
                  `BAND_FACT:  led_green <= 1'b1;
                  default:     led_green <= 1'b0;
               endcase
            end
            S_TEACH: led_green <= fast_on_r;
            S_LTYPE: begin
               led_green <= (label_type == `TYPE_PAPER);
               led_red   <= (label_type == `TYPE_METAL);
            end
            S_SHOW: begin
               led_green <= blink_on_r & ~show_red_r;
               led_red   <= blink_on_r & show_red_r;
            end
            default: led_green <= blink_on_r;
         endcase
      end
   end

   // ************************************
   // ahb-lite registers and interrupts
   // ************************************
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r  <= 1'b0;
         rd_pend_r  <= 1'b0;
         addr_r     <= 8'h00;
         hrdata     <= 32'h00000000;
         lock_r     <= 1'b0;
         int_stat_r <= {`INT_W{1'b0}};
         int_mask_r <= {`INT_W{1'b0}};
      end else begin
         if (hreadyout) begin
            wr_pend_r <= acc & hwrite;
            rd_pend_r <= acc & ~hwrite;
            if (acc)
               addr_r <= haddr[7:0];
         end else begin
            rd_pend_r <= 1'b0;
         end
         if (rd_pend_r) begin
            case (addr_r)
               `REG_CTRL:     hrdata <= {31'h00000000, lock_r};
               `REG_CFG:      hrdata <= {19'h00000, offset, 7'h00, label_type};
               `REG_STATUS:   hrdata <= {17'h00000, state_r, 5'h00, tok_r, btn_level, sw_out};
               `REG_INT_STAT: hrdata <= {28'h0000000, int_stat_r};
               `REG_INT_MASK: hrdata <= {28'h0000000, int_mask_r};
               default:       hrdata <= 32'h00000000;
            endcase
         end
         if (wr_pend_r && addr_r == `REG_CTRL)
            lock_r <= hwdata[`CTRL_LOCK_BIT];
         if (wr_pend_r && addr_r == `REG_INT_MASK)
            int_mask_r <= hwdata[`INT_W-1:0];
         // a new event wins over a write-one-to-clear in the same cycle
         if (wr_pend_r && addr_r == `REG_INT_STAT)
            int_stat_r <= (int_stat_r & ~hwdata[`INT_W-1:0]) | ev;
         else
            int_stat_r <= int_stat_r | ev;
      end
   end

endmodule // label_gap_sensor_setup_fsm

// ===== dv/label_gap_sensor_setup_fsm_properties.sv
// port assertions for the label/gap sensor controller
module lg_props (
   input wire logic       hclk,
   input wire logic       hresetn,
   input wire logic       hreadyout,
   input wire logic       label_pin,
   input wire logic       teach_done,
   input wire logic       teach_ok,
   input wire logic       sw_out,
   input wire logic       led_green,
   input wire logic       led_red,
   input wire logic       teach_start,
   input wire logic [4:0] offset
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ****************
   // sequences
   // ****************
   sequence s_fast; ##[0:10] !led_green ##[1:8] led_green; endsequence
   sequence s_calm; !led_red [*8]; endsequence
   // ****************
   // properties
   // ****************
   property p_sw; $past(hresetn, 4) |-> sw_out == $past(label_pin, 3); endproperty
   property p_col; !(led_green && led_red); endproperty
   property p_offs; offset >= 5'h01 && offset <= 5'h14; endproperty
   property p_start; teach_start |=> !teach_start; endproperty
   property p_blink; teach_start |=> s_fast; endproperty
   property p_ok; teach_done && teach_ok |=> s_calm; endproperty
   property p_fail; teach_done && !teach_ok |=> ##[0:12] led_red; endproperty
   property p_ready; !hreadyout |=> hreadyout; endproperty
   a_sw: assert property (p_sw) else $error("switch output off label");
   a_col: assert property (p_col) else $error("both led colours lit");
   a_offs: assert property (p_offs) else $error("offset out of range");
   a_start: assert property (p_start) else $error("teach start too long");
   a_blink: assert property (p_blink) else $error("no fast blink");
   a_ok: assert property (p_ok) else $error("red on teach success");
   a_fail: assert property (p_fail) else $error("no red on teach failure");
   a_ready: assert property (p_ready) else $error("wait state too long");
endmodule // lg_props

bind label_gap_sensor_setup_fsm lg_props chk (.hclk, .hresetn, .hreadyout, .label_pin, .teach_done, .teach_ok,
   .sw_out, .led_green, .led_red, .teach_start, .offset);

// ===== dv/operator_model.sv
// operator button, label web and teach front end
module operator_model (
   input  wire logic hclk,
   input  wire logic teach_start,
   output logic      btn_pin,
   output logic      label_pin,
   output logic      teach_done,
   output logic      teach_ok
);
   timeunit 1ns;
   timeprecision 1ps;
   int lat = 30;
   bit ok_nxt = 1;
   int lab_mode = 0;
   int n = 0;
   int cnt = 0;
   initial begin
      btn_pin = 0;
      label_pin = 0;
      teach_done = 0;
      teach_ok = 0;
   end
   always @(posedge hclk) begin
      n <= n + 1;
      if (lab_mode != 0) label_pin <= (lab_mode == 1);
      else if (n % 16 == 0) label_pin <= 1'($urandom);
      teach_done <= 0;
      // result level means nothing away from the done pulse
      teach_ok <= 1'($urandom);
      if (teach_start) cnt <= lat;
      else if (cnt > 0) cnt <= cnt - 1;
      if (!teach_start && cnt == 1) begin
         teach_done <= 1;
         teach_ok <= ok_nxt;
      end
   end
   task down(); btn_pin <= 1; endtask
   task up(); btn_pin <= 0; endtask
endmodule // operator_model

// ===== dv/label_gap_sensor_setup_fsm_test.sv
// self-checking bench for the label/gap sensor controller
`include "label_gap_defs.vh"
module label_gap_sensor_setup_fsm_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        hclk, hresetn, hsel, hwrite;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        hreadyout, hresp, btn_pin, label_pin, teach_done, teach_ok;
   logic        sw_out, led_green, led_red, teach_start, label_type, irq;
   logic [4:0]  offset;
   int          miscompares = 0, compares = 0, m_type = 0, m_offs = 6;
   int          on_n, off_n, g, r;
   bit          lq[$];
   always #4 hclk = ~hclk;
   label_gap_sensor_setup_fsm #(.T_DEB(4), .T_2S(40), .T_10S(100), .T_15S(150), .T_20S(200), .T_IDLE(100),
      .T_SLOW_HALF(5), .T_FAST_HALF(3)) uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .btn_pin, .label_pin, .teach_done, .teach_ok, .sw_out,
      .led_green, .led_red, .teach_start, .label_type, .offset, .irq);
   operator_model op (.hclk, .teach_start, .btn_pin, .label_pin, .teach_done, .teach_ok);
   // ****************
   // tasks
   // ****************
   task conclude();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task check(input logic [31:0] got, exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_hi(ref logic s, input int lim);
      int n = 0;
      while (s !== 1'b1 && n < lim) begin @(posedge hclk); n++; end
      if (n >= lim) begin miscompares++; conclude(); end
   endtask
   task automatic bus(input logic w, input logic [31:0] a, d);
      int n = 0;
      hsel <= 1; htrans <= 2'h2; haddr <= a; hwrite <= w; hsize <= 3'h2;
      do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
      hsel <= 0; htrans <= 2'h0; hwdata <= d;
      do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
      rd = hrdata;
      if (n >= 50) begin miscompares++; conclude(); end
   endtask
   task rchk(input logic [31:0] a, exp);
      bus(0, a, 0);
      check(rd, exp);
      check(hresp, 1'b0);
   endtask
   task cfg_chk();
      rchk(`REG_CFG, m_offs * 256 + m_type);
      check({19'h0, offset, 7'h0, label_type}, m_offs * 256 + m_type);
   endtask
   task ints(input logic [31:0] e);
      rchk(`REG_INT_STAT, e);
      check(irq, e != 0);
      bus(1, `REG_INT_STAT, e);
      @(posedge hclk);
      check(irq, 0);
   endtask
   // green led sampled over the last 16 cycles of the press
   task hold(input int c);
      on_n = 0; off_n = 0;
      op.down();
      for (int i = 0; i < c; i++) begin
         @(posedge hclk);
         if (i >= c - 16) begin if (led_green === 1'b1) on_n++; else off_n++; end
      end
      op.up();
   endtask
   task falls(input int c);
      logic pg, pr;
      g = 0; r = 0; pg = led_green; pr = led_red;
      repeat (c) begin
         @(posedge hclk);
         if (pg === 1'b1 && led_green === 1'b0) g++;
         if (pr === 1'b1 && led_red === 1'b0) r++;
         pg = led_green; pr = led_red;
      end
   endtask
   // ****************
   // switch output model
   // ****************
   always @(posedge hclk) if (hresetn) begin
      lq.push_back(label_pin);
      if (lq.size() > 3) check(sw_out, lq.pop_front());
   end
   initial begin repeat (100000) @(posedge hclk); miscompares++; conclude(); end
   // ****************
   // scenarios
   // ****************
   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'h0;
      hsize = 3'h2;
      void'($urandom(57752));
      repeat (2) @(posedge hclk);
      hresetn <= 1;
      @(posedge hclk);
      check({label_type, offset}, {1'b0, `OFFS_PAPER});
      bus(1, `REG_INT_MASK, 32'hf);
      rchk(`REG_INT_MASK, 32'hf);
      bus(1, 32'h20, 32'hffffffff);
      rchk(32'h20, 0);
      repeat (200) @(posedge hclk);
      bus(1, `REG_CFG, 32'h1f01); m_offs = 20; m_type = 1;
      cfg_chk();
      bus(1, `REG_CFG, 32'h0); m_offs = 1; m_type = 0;
      cfg_chk();
      op.lab_mode = 1; repeat (12) @(posedge hclk);
      check({led_red, led_green}, 2'b01);
      op.lab_mode = 2; repeat (12) @(posedge hclk);
      check({led_red, led_green}, 2'b00);
      hold($urandom_range(30, 10)); repeat (30) @(posedge hclk);
      rchk(`REG_STATUS, 32'h100);
      cfg_chk();
      ints(0);
      op.lat = $urandom_range(60, 20); op.ok_nxt = 1;
      hold(80); check(on_n, 16);
      wait_hi(teach_start, 40);
      wait_hi(teach_done, 200);
      // skip the last fast-blink cycles before counting slow blinks
      repeat (2) @(posedge hclk);
      falls(50); check(g, 2);
      check(r, 0);
      ints(32'h3);
      bus(1, `REG_INT_MASK, 0);
      op.lat = $urandom_range(60, 20); op.ok_nxt = 0;
      hold(80);
      wait_hi(teach_start, 40);
      wait_hi(teach_done, 200);
      falls(60); check(r, 4);
      check(irq, 0);
      bus(1, `REG_INT_MASK, 32'hf);
      ints(32'h5);
      hold(130); check(on_n != 0 && off_n != 0, 1);
      repeat (20) @(posedge hclk);
      check({led_red, led_green}, 2'b01);
      for (int i = 0; i < 3; i++) begin
         hold($urandom_range(25, 10)); repeat (25) @(posedge hclk);
         m_type ^= 1;
         check({led_red, led_green, label_type}, m_type ? 3'b101 : 3'b010);
      end
      repeat (55) @(posedge hclk);
      rchk(`REG_STATUS, 32'h800);
      repeat (40) @(posedge hclk);
      rchk(`REG_STATUS, 32'h100);
      cfg_chk();
      ints(32'h9);
      bus(1, `REG_CFG, 32'h0201); m_offs = 2; m_type = 1;
      hold(175); check(on_n, 0);
      falls(40); check(g + r, 2);
      for (int i = 0; i < 3; i++) begin
         hold(i < 2 ? 60 : 15);
         m_offs = (i < 2) ? 1 : 2;
         falls(40); check(g + r, m_offs);
         check(offset, m_offs);
      end
      repeat (130) @(posedge hclk);
      rchk(`REG_STATUS, 32'h100);
      cfg_chk();
      ints(32'h9);
      hold(230); check(on_n, 16);
      // steady green of the hold ends before the blink code starts
      repeat (9) @(posedge hclk);
      falls(40); check(g, 2);
      check(r, 0);
      m_type = 0; m_offs = 6;
      cfg_chk();
      ints(32'h9);
      conclude();
   end
endmodule // label_gap_sensor_setup_fsm_test
